// ---- core/perf_monitor_pkg.sv ----
// shared constants for the performance monitor event counters
package perf_monitor_pkg;

    localparam int          NUM_COUNTERS        = 8;         // counters 0..7
    localparam int          COUNTER_WIDTH       = 32;        // each counter width
    localparam int          ADDR_WIDTH          = 4;         // register port address width
    localparam int          DATA_WIDTH          = 32;        // register port data width
    localparam int          EVENT_BUS_WIDTH     = 16;        // event output bus width
    localparam int          PROC_TAG_EVENT_BIT  = 12;        // event bus bit for tag writes

    // register offsets (word index on the plain port)
    localparam logic [3:0]  MONITOR_CONTROL_OFS = 4'h0;      // global enable
    localparam logic [3:0]  CNT_ENABLE_SET_OFS  = 4'h1;      // write one to enable
    localparam logic [3:0]  CNT_ENABLE_CLR_OFS  = 4'h2;      // write one to disable
    localparam logic [3:0]  COUNTER_SELECT_OFS  = 4'h3;      // selected counter index
    localparam logic [3:0]  EVENT_TYPE_OFS      = 4'h4;      // event code of selected
    localparam logic [3:0]  EVENT_COUNT_OFS     = 4'h5;      // count of selected

    // field positions
    localparam int          GLOBAL_ENABLE_BIT   = 0;         // bit of monitor control
    localparam int          SELECT_MSB          = 2;         // select field top bit
    localparam int          EVENT_CODE_MSB      = 7;         // event code field top bit

    // event codes and reset values
    localparam logic [7:0]  EVT_PROC_TAG_WRITE  = 8'h0B;     // process-tag write event
    localparam logic [7:0]  EVENT_CODE_RESET    = 8'h00;     // code after reset
    localparam logic [31:0] COUNTER_RESET       = 32'h0000_0000; // count after reset

endpackage : perf_monitor_pkg

// ---- core/event_counter.sv ----
// one event counter with its own event code and enable
`timescale 1ns/1ns
module event_counter
    import perf_monitor_pkg::*;
(
    input  wire logic        clk_in,          // core clock
    input  wire logic        rst_n_in,        // async reset, active low
    input  wire logic        count_en_in,     // global and local enable both set
    input  wire logic        tag_write_in,    // qualified process-tag write event
    input  wire logic        code_we_in,      // load event code
    input  wire logic [7:0]  code_in,         // new event code
    input  wire logic        cnt_we_in,       // load counter value
    input  wire logic [31:0] cnt_in,          // new counter value
    output logic      [7:0]  code_out,        // current event code
    output logic      [31:0] cnt_out          // current count
);

    typedef struct packed {
        logic [7:0]  code;                   // event code field
        logic [31:0] cnt;                    // counter value
    } ctr_state_s;

    ctr_state_s state_reg;                   // registered state
    ctr_state_s state_next;                  // next state

    ////////////////////////////////////////////////////////////////////////////////
    // next state: software loads win over counting
    always_comb
    begin
        state_next = state_reg;
        if (code_we_in)
        begin
            state_next.code = code_in;
        end
        if (cnt_we_in)
        begin
            state_next.cnt = cnt_in;         // software preset
        end
        else if (count_en_in && tag_write_in && state_reg.code == EVT_PROC_TAG_WRITE)
        begin
            state_next.cnt = state_reg.cnt + 32'h0000_0001;
        end
    end

    // state register
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_reg.code <= EVENT_CODE_RESET;
            state_reg.cnt  <= COUNTER_RESET;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign code_out = state_reg.code;
    assign cnt_out  = state_reg.cnt;

    ////////////////////////////////////////////////////////////////////////////////
    // checks on counting
    property p_count_step;
        @(posedge clk_in) disable iff (!rst_n_in)
        (count_en_in && tag_write_in && !cnt_we_in && code_out == EVT_PROC_TAG_WRITE)
        |=> (cnt_out == $past(cnt_out) + 32'h0000_0001);
    endproperty
    a_count_step : assert property (p_count_step)
        else $error("counter did not step on tag write");

    property p_hold_no_event;
        @(posedge clk_in) disable iff (!rst_n_in)
        (!cnt_we_in && !(count_en_in && tag_write_in && code_out == EVT_PROC_TAG_WRITE))
        |=> $stable(cnt_out);
    endproperty
    a_hold_no_event : assert property (p_hold_no_event)
        else $error("counter moved without a qualified event");

    property p_wrap;
        @(posedge clk_in) disable iff (!rst_n_in)
        (count_en_in && tag_write_in && !cnt_we_in && code_out == EVT_PROC_TAG_WRITE
         && cnt_out == 32'hFFFF_FFFF) |=> (cnt_out == 32'h0000_0000);
    endproperty
    a_wrap : assert property (p_wrap)
        else $error("counter did not wrap to zero");

endmodule : event_counter

// ---- core/perf_monitor_unit.sv ----
// performance monitor unit counting process-tag register writes
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
module perf_monitor_unit
    import perf_monitor_pkg::*;
(
    input  wire logic                                    CLK_IN,        // core clock 100 MHz
    input  wire logic                                    RST_N_IN,      // async reset, low
    input  wire logic [perf_monitor_pkg::ADDR_WIDTH-1:0] ADDR_IN,       // register index
    input  wire logic [perf_monitor_pkg::DATA_WIDTH-1:0] WDATA_IN,      // write data
    input  wire logic                                    WR_IN,         // write strobe
    input  wire logic                                    RD_IN,         // read strobe
    input  wire logic                                    TAG_ACCESS_IN, // retired tag access
    input  wire logic                                    TAG_WRITE_IN,  // access is a write
    output logic      [perf_monitor_pkg::DATA_WIDTH-1:0] RDATA_OUT,     // read data, next cycle
    output logic [perf_monitor_pkg::EVENT_BUS_WIDTH-1:0] EVENT_BUS_OUT  // event output bus
);

    import perf_monitor_pkg::*;

    typedef struct packed {
        logic                         global_en;   // monitor control enable
        logic [NUM_COUNTERS-1:0]      cnt_en;      // per-counter enable bits
        logic [SELECT_MSB:0]          sel;         // selected counter index
        logic [DATA_WIDTH-1:0]        rdata;       // read data register
        logic [EVENT_BUS_WIDTH-1:0]   evt_bus;     // event output register
    } pmu_state_s;

    pmu_state_s                  state_reg;       // registered state
    pmu_state_s                  state_next;      // next state
    logic                        tag_wr_evt;      // qualified write event
    logic [NUM_COUNTERS-1:0]     code_we;         // per-counter code load
    logic [NUM_COUNTERS-1:0]     cnt_we;          // per-counter value load
    logic [7:0]                  codes [NUM_COUNTERS];  // counter event codes
    logic [31:0]                 counts [NUM_COUNTERS]; // counter values

    ////////////////////////////////////////////////////////////////////////////////
    // event qualification: only write instructions count
    assign tag_wr_evt = TAG_ACCESS_IN && TAG_WRITE_IN;

    // per-counter write decode, steered by the select register
    always_comb
    begin
        code_we = '0;
        cnt_we  = '0;
        if (WR_IN && ADDR_IN == EVENT_TYPE_OFS)
        begin
            code_we[state_reg.sel] = 1'b1;
        end
        if (WR_IN && ADDR_IN == EVENT_COUNT_OFS)
        begin
            cnt_we[state_reg.sel] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // the eight counters
    genvar gi;
    generate
        for (gi = 0; gi < NUM_COUNTERS; gi++)
        begin : g_ctr
            event_counter u_ctr (
                .clk_in       (CLK_IN),
                .rst_n_in     (RST_N_IN),
                .count_en_in  (state_reg.global_en && state_reg.cnt_en[gi]),
                .tag_write_in (tag_wr_evt),
                .code_we_in   (code_we[gi]),
                .code_in      (WDATA_IN[EVENT_CODE_MSB:0]),
                .cnt_we_in    (cnt_we[gi]),
                .cnt_in       (WDATA_IN),
                .code_out     (codes[gi]),
                .cnt_out      (counts[gi])
            );

            // index of this counter on the select register
            localparam logic [SELECT_MSB:0] CTR_INDEX = (SELECT_MSB+1)'(gi);

            // event code write aimed at this counter
            sequence s_code_write_here;
                WR_IN && ADDR_IN == EVENT_TYPE_OFS && state_reg.sel == CTR_INDEX;
            endsequence

            // count read aimed at this counter
            sequence s_count_read_here;
                RD_IN && ADDR_IN == EVENT_COUNT_OFS && state_reg.sel == CTR_INDEX;
            endsequence

            // no movement while the monitor is off, unless software presets it
            property p_global_gate;
                @(posedge CLK_IN) disable iff (!RST_N_IN)
                (!state_reg.global_en && !cnt_we[gi]) |=> $stable(counts[gi]);
            endproperty
            a_global_gate : assert property (p_global_gate)
                else $error("counter moved with monitor disabled");

            // code write lands in the selected counter
            property p_select_steer;
                @(posedge CLK_IN) disable iff (!RST_N_IN)
                s_code_write_here |=> (codes[gi] == $past(WDATA_IN[EVENT_CODE_MSB:0]));
            endproperty
            a_select_steer : assert property (p_select_steer)
                else $error("event code not loaded into selected counter");

            // code of an unselected counter stays put
            property p_code_hold;
                @(posedge CLK_IN) disable iff (!RST_N_IN)
                !(WR_IN && ADDR_IN == EVENT_TYPE_OFS && state_reg.sel == CTR_INDEX)
                |=> $stable(codes[gi]);
            endproperty
            a_code_hold : assert property (p_code_hold)
                else $error("event code changed on another counter");

            // count read returns the selected counter
            property p_count_read;
                @(posedge CLK_IN) disable iff (!RST_N_IN)
                s_count_read_here |=> (RDATA_OUT == $past(counts[gi]));
            endproperty
            a_count_read : assert property (p_count_read)
                else $error("count read did not return selected counter");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // register writes, read mux and event bus
    always_comb
    begin
        state_next = state_reg;
        state_next.rdata = '0;                    // data only in the cycle after a read
        state_next.evt_bus = '0;
        state_next.evt_bus[PROC_TAG_EVENT_BIT] = tag_wr_evt;
        if (WR_IN)
        begin
            unique case (ADDR_IN)
                MONITOR_CONTROL_OFS: state_next.global_en = WDATA_IN[GLOBAL_ENABLE_BIT];
                CNT_ENABLE_SET_OFS:  state_next.cnt_en = state_reg.cnt_en
                                         | WDATA_IN[NUM_COUNTERS-1:0];
                CNT_ENABLE_CLR_OFS:  state_next.cnt_en = state_reg.cnt_en
                                         & ~WDATA_IN[NUM_COUNTERS-1:0];
                COUNTER_SELECT_OFS:  state_next.sel = WDATA_IN[SELECT_MSB:0];
                default:             ; // event type and count writes go to the counters; other offsets ignore writes
            endcase
        end
        if (RD_IN)
        begin
            unique case (ADDR_IN)
                MONITOR_CONTROL_OFS: state_next.rdata = {31'h0, state_reg.global_en};
                CNT_ENABLE_SET_OFS,
                CNT_ENABLE_CLR_OFS:  state_next.rdata = {24'h0, state_reg.cnt_en};
                COUNTER_SELECT_OFS:  state_next.rdata = {29'h0, state_reg.sel};
                EVENT_TYPE_OFS:      state_next.rdata = {24'h0, codes[state_reg.sel]};
                EVENT_COUNT_OFS:     state_next.rdata = counts[state_reg.sel];
                default:             state_next.rdata = '0; // unmapped reads zero
            endcase
        end
    end

    // state register
    always_ff @(posedge CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign RDATA_OUT     = state_reg.rdata;
    assign EVENT_BUS_OUT = state_reg.evt_bus;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_tag_write;
        TAG_ACCESS_IN && TAG_WRITE_IN;
    endsequence

    sequence s_tag_read;
        TAG_ACCESS_IN && !TAG_WRITE_IN;
    endsequence

    property p_evt_on_write;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        s_tag_write |=> EVENT_BUS_OUT[PROC_TAG_EVENT_BIT];
    endproperty
    a_evt_on_write : assert property (p_evt_on_write)
        else $error("event bit missing after tag write");

    property p_no_evt_on_read;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        s_tag_read |=> !EVENT_BUS_OUT[PROC_TAG_EVENT_BIT];
    endproperty
    a_no_evt_on_read : assert property (p_no_evt_on_read)
        else $error("event bit raised on tag read");

    // event bit only ever follows a qualified write
    property p_evt_quiet;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        !(TAG_ACCESS_IN && TAG_WRITE_IN) |=> !EVENT_BUS_OUT[PROC_TAG_EVENT_BIT];
    endproperty
    a_evt_quiet : assert property (p_evt_quiet)
        else $error("event bit raised without a tag write");

    // unused event bus bits stay low
    property p_evt_other_zero;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        (EVENT_BUS_OUT[EVENT_BUS_WIDTH-1:PROC_TAG_EVENT_BIT+1] == '0)
        && (EVENT_BUS_OUT[PROC_TAG_EVENT_BIT-1:0] == '0);
    endproperty
    a_evt_other_zero : assert property (p_evt_other_zero)
        else $error("unused event bus bit raised");

    property p_enable_set;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        (WR_IN && ADDR_IN == CNT_ENABLE_SET_OFS)
        |=> ((state_reg.cnt_en & $past(WDATA_IN[NUM_COUNTERS-1:0]))
             == $past(WDATA_IN[NUM_COUNTERS-1:0]));
    endproperty
    a_enable_set : assert property (p_enable_set)
        else $error("enable set write did not set bits");

    // enable clear write drops the named bits
    property p_enable_clear;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        (WR_IN && ADDR_IN == CNT_ENABLE_CLR_OFS)
        |=> ((state_reg.cnt_en & $past(WDATA_IN[NUM_COUNTERS-1:0])) == '0);
    endproperty
    a_enable_clear : assert property (p_enable_clear)
        else $error("enable clear write did not clear bits");

    // monitor control write loads the global enable
    property p_global_write;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        (WR_IN && ADDR_IN == MONITOR_CONTROL_OFS)
        |=> (state_reg.global_en == $past(WDATA_IN[GLOBAL_ENABLE_BIT]));
    endproperty
    a_global_write : assert property (p_global_write)
        else $error("global enable not loaded");

    // select write loads the counter index
    property p_select_write;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        (WR_IN && ADDR_IN == COUNTER_SELECT_OFS)
        |=> (state_reg.sel == $past(WDATA_IN[SELECT_MSB:0]));
    endproperty
    a_select_write : assert property (p_select_write)
        else $error("counter select not loaded");

    // read data stands only in the cycle after a read
    property p_read_idle;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        !RD_IN |=> (RDATA_OUT == '0);
    endproperty
    a_read_idle : assert property (p_read_idle)
        else $error("read data not zero outside a read answer");

endmodule : perf_monitor_unit

// ---- sim/tag_retire_model.sv ----
// retire logic model that reports process-tag register accesses
`timescale 1ns/1ns
module tag_retire_model
(
    input  wire logic clk_in,        // core clock
    output logic      access_out,    // retired tag access pulse
    output logic      write_out      // access is a write
);
    ////////////////////////////////////////////////////////////////////////////////////
    // idle state: no access, qualifier left at a meaningless level
    initial
    begin
        access_out = 1'b0;
        write_out  = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // n back to back retired accesses, one per cycle
    task automatic burst(input int n, input logic is_wr);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk_in);
            access_out <= 1'b1;
            write_out  <= is_wr;
        end
        @(posedge clk_in);
        access_out <= 1'b0;
        write_out  <= ~is_wr;                               // qualifier no longer valid
    endtask : burst
endmodule : tag_retire_model

// ---- sim/perf_monitor_unit_bench.sv ----
// self-checking bench for the process-tag write event counters
`timescale 1ns/1ns
module perf_monitor_unit_bench;
    import perf_monitor_pkg::*;
    logic        clk = 1'b0;   // core clock
    logic        rst_n = 1'b0; // reset, active low
    logic [3:0]  addr = 4'h0;  // register index
    logic [31:0] wdata = 32'h0;// write data
    logic        wr = 1'b0;    // write strobe
    logic        rd = 1'b0;    // read strobe
    logic        access;       // from retire model
    logic        is_write;     // from retire model
    logic [31:0] rdata;        // read data
    logic [15:0] ev_bus;       // event output bus
    int          errors = 0;   // mismatches
    int          num_checks = 0; // comparisons
    int          ev_seen = 0;  // bit 12 pulses seen
    int          bad_bits = 0; // other event bits seen high
    int          ev0;          // pulse count snapshot

    always #5 clk = ~clk;

    perf_monitor_unit i_dut (.CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .TAG_ACCESS_IN(access), .TAG_WRITE_IN(is_write),
        .RDATA_OUT(rdata), .EVENT_BUS_OUT(ev_bus));
    tag_retire_model i_retire (.clk_in(clk), .access_out(access), .write_out(is_write));

    ////////////////////////////////////////////////////////////////////////////////////
    // event bus monitor
    always @(posedge clk)
    begin
        if (ev_bus[12] === 1'b1)
            ev_seen++;
        if ({ev_bus[15:13], ev_bus[11:0]} !== 15'h0000)
            bad_bits++;
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic test_done();
        if (errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), exp, rdata);
    endtask : rd_chk

    ////////////////////////////////////////////////////////////////////////////////////
    // watchdog
    initial
    begin
        #20000;
        errors++;
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++)
            rd_chk(i[3:0], 32'h0000_0000);
        rd_chk(4'hF, 32'h0000_0000);                        // unmapped
        wr_reg(COUNTER_SELECT_OFS, 32'h0000_0003);
        wr_reg(EVENT_TYPE_OFS, {24'h0, EVT_PROC_TAG_WRITE});
        wr_reg(CNT_ENABLE_SET_OFS, 32'h0000_0008);
        wr_reg(MONITOR_CONTROL_OFS, 32'h0000_0001);
        wr_reg(COUNTER_SELECT_OFS, 32'h0000_0005);
        wr_reg(EVENT_TYPE_OFS, 32'h0000_0011);
        wr_reg(COUNTER_SELECT_OFS, 32'h0000_0003);
        rd_chk(EVENT_TYPE_OFS, 32'h0000_000B);
        rd_chk(CNT_ENABLE_SET_OFS, 32'h0000_0008);
        rd_chk(MONITOR_CONTROL_OFS, 32'h0000_0001);
        ev0 = ev_seen;
        i_retire.burst(5, 1'b1);
        rd_chk(EVENT_COUNT_OFS, 32'h0000_0005);
        chk("write pulses", 32'h0000_0005, ev_seen - ev0);
        ev0 = ev_seen;
        i_retire.burst(4, 1'b0);
        rd_chk(EVENT_COUNT_OFS, 32'h0000_0005);
        chk("read pulses", 32'h0000_0000, ev_seen - ev0);
        wr_reg(COUNTER_SELECT_OFS, 32'h0000_0005);
        rd_chk(EVENT_COUNT_OFS, 32'h0000_0000);
        rd_chk(EVENT_TYPE_OFS, 32'h0000_0011);
        wr_reg(COUNTER_SELECT_OFS, 32'h0000_0003);
        wr_reg(MONITOR_CONTROL_OFS, 32'h0000_0000);
        i_retire.burst(2, 1'b1);
        rd_chk(EVENT_COUNT_OFS, 32'h0000_0005);
        wr_reg(MONITOR_CONTROL_OFS, 32'h0000_0001);
        wr_reg(CNT_ENABLE_CLR_OFS, 32'h0000_0008);
        i_retire.burst(2, 1'b1);
        rd_chk(EVENT_COUNT_OFS, 32'h0000_0005);
        wr_reg(CNT_ENABLE_SET_OFS, 32'h0000_0008);
        wr_reg(EVENT_COUNT_OFS, 32'hFFFF_FFFF);
        i_retire.burst(2, 1'b1);
        rd_chk(EVENT_COUNT_OFS, 32'h0000_0001);
        chk("other event bits", 32'h0000_0000, bad_bits);
        test_done();
    end
endmodule : perf_monitor_unit_bench
